// File: hw/sadc_core.sv
// conversion control and serial readout of a 12-bit converter
// Behaviour
// - ready to convert once not powered down and the wake delay has passed
// - select falling edge holds sample, starts
// - internal 8.5 us timer, done drives high
// - data leaves high-z, low while converting
// - result latched, readable any time after
// - after done goes high, data changes only on clock falling edges
// - first falling edge gives MSB, then rest
// - extra clocks shift zeros, harmless
// - straight binary result, 4096 codes
// - power-down low shuts device down
// - select high before done aborts conversion
`timescale 1ns/1ps
module sadc_core
    import sadc_pkg::*;
#(
    parameter int WAKE_CYC = SADC_WAKE_CYC
)
(
    // system
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // pins from host
    input  wire logic        sel_n,
    input  wire logic        sclk,
    input  wire logic        power_down_n,
    // sampled analog value from the converter core
    input  wire logic [11:0] sample_code,
    // serial data pin
    output logic             dout_o,
    output logic             dout_oe,
    // status
    output logic             hold_q,
    output logic             asleep_q
);
    logic [1:0]  sel_sync_q;
    logic [1:0]  clk_sync_q;
    logic [1:0]  pd_sync_q;
    logic        sel_prev_q;
    logic        clk_prev_q;
    logic [11:0] result_q;
    logic [11:0] result_d;
    logic [3:0]  sent_q;
    logic [6:0]  timer_q;
    logic [6:0]  wake_q;
    sadc_state_t state_q;
    sadc_state_t state_d;

    wire sel_fall  = sel_prev_q & ~sel_sync_q[1];
    wire sel_high  = sel_sync_q[1];
    wire clk_fall  = clk_prev_q & ~clk_sync_q[1];
    wire awake     = pd_sync_q[1] && wake_q == 7'h00;
    wire conv_done = timer_q == 7'(SADC_CONV_CYC - 1);
    // straight binary code of held sample
    wire [11:0] held_code = sample_code;

    always_ff @(posedge sys_clk)
    begin
        sel_sync_q <= {sel_sync_q[0], sel_n};
        clk_sync_q <= {clk_sync_q[0], sclk};
        pd_sync_q  <= {pd_sync_q[0], power_down_n};
        sel_prev_q <= sel_sync_q[1];
        clk_prev_q <= clk_sync_q[1];
    end

    // wake timer restarts whenever power-down is asserted
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            wake_q <= 7'(WAKE_CYC);
        else if (!pd_sync_q[1])
            wake_q <= 7'(WAKE_CYC);
        else if (wake_q != 7'h00)
            wake_q <= wake_q - 7'h01;
    end

    always_comb
    begin
        state_d  = state_q;
        result_d = result_q;
        if (sel_high || !awake)
            state_d = SADC_IDLE;
        else if (sel_fall)
            state_d = SADC_CONV;
        else if (state_q == SADC_CONV && conv_done)
        begin
            state_d  = SADC_SHIFT;
            result_d = held_code;
        end
        else if (state_q == SADC_SHIFT && clk_fall)
            result_d = {result_q[10:0], 1'b0};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_q  <= SADC_IDLE;
            result_q <= SADC_RESULT_RST;
            sent_q   <= SADC_CNT_RST;
            timer_q  <= 7'h00;
        end
        else
        begin
            state_q  <= state_d;
            result_q <= result_d;
            timer_q  <= (state_d == SADC_CONV && state_q == SADC_CONV)
                        ? timer_q + 7'h01 : 7'h00;
            if (state_d != SADC_SHIFT)
                sent_q <= SADC_CNT_RST;
            else if (clk_fall && sent_q != 4'hF)
                sent_q <= sent_q + 4'h1;
        end
    end

    // pin outputs; the leading one stands until the first falling edge
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dout_o   <= 1'b0;
            dout_oe  <= 1'b0;
            hold_q   <= 1'b0;
            asleep_q <= 1'b1;
        end
        else
        begin
            dout_oe  <= state_d != SADC_IDLE;
            hold_q   <= state_d == SADC_CONV;
            asleep_q <= !awake;
            if (state_d == SADC_CONV || state_d == SADC_IDLE)
                dout_o <= 1'b0;
            else if (state_q == SADC_CONV)
                dout_o <= 1'b1;
            else if (clk_fall)
                dout_o <= result_q[11];
        end
    end

    sequence s_start;
        sel_fall && !sel_high && awake;
    endsequence

    chk_conv_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_start ##1 (!sel_high && awake)[*8] |-> !dout_o)
        else $error("done flagged too early");
    chk_low_in_conv: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_start |=> dout_oe && !dout_o)
        else $error("output not low after start");
    chk_highz_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel_high |=> !dout_oe)
        else $error("output driven while deselected");
    chk_only_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == SADC_SHIFT && state_d == SADC_SHIFT && !clk_fall
         && $past(state_q) == SADC_SHIFT) |=> $stable(dout_o))
        else $error("data moved without clock fall");
    chk_eoc_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == SADC_CONV && conv_done && state_d == SADC_SHIFT)
        |=> dout_o && dout_oe)
        else $error("end of conversion not high");
    chk_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == SADC_SHIFT && state_d == SADC_SHIFT && clk_fall
         && sent_q == 4'h0) |=> dout_o == $past(result_q[11]))
        else $error("msb not first");
    chk_sleep_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !pd_sync_q[1] |=> !dout_oe && asleep_q)
        else $error("active while powered down");
    chk_zero_tail: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == SADC_SHIFT && state_d == SADC_SHIFT && clk_fall
         && sent_q >= 4'hC) |=> !dout_o)
        else $error("trailing bit not zero");
endmodule

// File: hw/sadc_pkg.sv
// constants and types for the serial converter readout block
package sadc_pkg;
    localparam int          SADC_CLK_HZ       = 10_000_000;
    localparam int          SADC_BITS         = 12;
    localparam int          SADC_FRAME_BITS   = SADC_BITS + 1;
    // conversion time, in nanoseconds (8.5 us), rounded down to cycles
    localparam int          SADC_CONV_NS      = 8500;
    localparam int          SADC_CONV_CYC     =
        (SADC_CONV_NS / 100) * (SADC_CLK_HZ / 10_000_000);
    // wake delay after power-down release, in nanoseconds (2 us)
    localparam int          SADC_WAKE_NS      = 2000;
    localparam int          SADC_WAKE_CYC     =
        (SADC_WAKE_NS / 100) * (SADC_CLK_HZ / 10_000_000);
    localparam logic [11:0] SADC_RESULT_RST   = 12'h000;
    localparam logic [3:0]  SADC_CNT_RST      = 4'h0;
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_CONV,
        SADC_SHIFT
    } sadc_state_t;
endpackage

// File: sim/sadc_host.sv
// host model: drives select, serial clock and power-down
`timescale 1ns/1ps
module sadc_host (
    // system
    input  wire logic sys_clk,
    // pins
    input  wire logic dout,
    output logic      sel_n,
    output logic      sclk,
    output logic      power_down_n
);
    initial {sel_n, sclk, power_down_n} = 3'b101;
    // every change lands 1 ns after an edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // 400 ns phases (1.25 MHz); idles low outside frames
    task automatic read(input int n, output logic [15:0] v);
        v = 16'h0000;
        for (int i = 0; i < n; i++)
        begin
            sclk = 1'b1;
            v = {v[14:0], dout};
            tick(4);
            sclk = 1'b0;
            tick(4);
        end
    endtask
endmodule

// File: sim/test_sadc_core.sv
// self-checking bench for the converter readout block
`timescale 1ns/1ps
module test_sadc_core;
    import sadc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] sample_code = 12'h000;
    logic [31:0] seed = 32'h565C;
    logic [15:0] got;
    logic        dout_o, dout_oe, hold_q, asleep_q, sel_n, sclk, pdn;
    logic [11:0] exp_q[$];
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n;
    // released line shows the inverse, never a stale level
    wire         dout_w = dout_oe ? dout_o : ~dout_o;
    always #50 sys_clk = ~sys_clk;
    sadc_core #(.WAKE_CYC(2)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .sel_n(sel_n), .sclk(sclk), .power_down_n(pdn),
        .sample_code(sample_code), .dout_o(dout_o), .dout_oe(dout_oe),
        .hold_q(hold_q), .asleep_q(asleep_q));
    sadc_host host (.sys_clk(sys_clk), .dout(dout_w), .sel_n(sel_n),
        .sclk(sclk), .power_down_n(pdn));
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            stop_test();
        end
    end
    task automatic frame(input logic [11:0] code);
        sample_code = code;
        exp_q.push_back(code);
        host.sel_n = 1'b0;
        n = 0;
        while (!(dout_oe === 1'b1 && dout_o === 1'b1) && n < 200)
        begin
            host.tick(1);
            n++;
            if (n == 10)
                check({15'h0, hold_q & dout_oe & ~dout_o}, 16'h1);
        end
        check({15'h0, n >= SADC_CONV_CYC && n <= SADC_CONV_CYC + 8}, 16'h1);
        host.read(16, got);
        check(got, {1'b1, exp_q.pop_front(), 3'h0});
        host.sel_n = 1'b1;
        host.tick(16);
        check({15'h0, dout_oe}, 16'h0);
    endtask
    initial
    begin
        host.tick(16);
        rst_n = 1'b1;
        host.tick(30);
        check({15'h0, asleep_q}, 16'h0);
        host.read(4, got);
        check({15'h0, dout_oe}, 16'h0);
        frame(12'hFFF);
        frame(12'h000);
        for (int k = 0; k < 6; k++)
        begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            frame(seed[11:0]);
        end
        // abort mid-conversion, then a fresh frame must follow
        host.sel_n = 1'b0;
        host.tick(20);
        host.sel_n = 1'b1;
        host.tick(8);
        check({14'h0, hold_q, dout_oe}, 16'h0);
        host.tick(15);
        frame(12'hA5C);
        // shutdown refuses select while power-down is low, awake again after release
        host.power_down_n = 1'b0;
        host.tick(8);
        check({15'h0, asleep_q}, 16'h1);
        host.sel_n = 1'b0;
        host.tick(8);
        check({15'h0, dout_oe}, 16'h0);
        host.sel_n = 1'b1;
        host.power_down_n = 1'b1;
        host.tick(20);
        check({15'h0, asleep_q}, 16'h0);
        frame(12'h3C1);
        stop_test();
    end
endmodule
